// [rtl/pspst_pkg.sv]
// shared constants and types for the pressure signal path with self-test
package pspst_pkg;

   // clocking
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned HZ_PER_MHZ    = 1_000_000;
   localparam int unsigned MOD_HZ        = 1_000_000;
   localparam int unsigned MOD_DIV       = CLK_HZ / MOD_HZ;
   localparam logic [4:0]  MOD_LAST      = 5'(MOD_DIV - 1);
   localparam logic [4:0]  MOD_HALF      = 5'(MOD_DIV / 2);
   localparam int unsigned ST_PERIOD_US  = 1000;
   localparam int unsigned ST_PERIOD_DEF = ST_PERIOD_US * (CLK_HZ / HZ_PER_MHZ);

   // decimation
   localparam int unsigned SINC1_RATIO = 24;
   localparam int unsigned SINC2_RATIO = 4;
   localparam logic [4:0]  SINC1_LAST  = 5'(SINC1_RATIO - 1);
   localparam logic [1:0]  SINC2_LAST  = 2'(SINC2_RATIO - 1);
   // 65536 / (24^3 * 4^3) = 2/27, as a Q20 multiplier
   localparam logic [16:0] NORM_MUL    = 17'h12F68;
   localparam int unsigned NORM_SHIFT  = 20;

   // trim and filter arithmetic
   localparam logic [15:0] TRIM_GAIN_ONE = 16'h4000;
   localparam int unsigned TRIM_SHIFT    = 14;
   localparam int unsigned NL_SHIFT      = 16;
   localparam int unsigned TCO_SHIFT     = 4;
   localparam int unsigned COEF_Q        = 22;
   localparam int unsigned IIR_FRAC      = 8;

   // self-test selector codes
   localparam logic [3:0] ST_OFF      = 4'h0;
   localparam logic [3:0] ST_CM       = 4'h1;
   localparam logic [1:0] ST_GRP_FIX  = 2'h1;
   localparam logic [1:0] ST_GRP_DIG  = 2'h3;
   localparam logic [3:0][15:0] DIG_VAL = {16'h78AC, 16'h807A, 16'h6C95, 16'h8171};
   localparam logic [3:0][15:0] FIX_VAL = {16'hFFFF, 16'h5555, 16'hAAAA, 16'h0000};

   // register map (byte addresses)
   localparam logic [7:0] A_CFG   = 8'h00;
   localparam logic [7:0] A_STAT  = 8'h04;
   localparam logic [7:0] A_SENSE = 8'h08;
   localparam logic [7:0] A_TRIM0 = 8'h0C;
   localparam logic [7:0] A_TRIM1 = 8'h10;
   localparam logic [7:0] A_IRQ   = 8'h14;
   localparam logic [7:0] A_MASK  = 8'h18;

   // field positions
   localparam int unsigned CFG_LPF  = 4;
   localparam int unsigned CFG_LOCK = 8;
   localparam int unsigned IRQ_W    = 4;
   localparam int unsigned IRQ_SMP  = 0;
   localparam int unsigned IRQ_FAIL = 1;
   localparam int unsigned IRQ_DONE = 2;
   localparam int unsigned IRQ_UV   = 3;

   typedef enum logic [2:0] {
      CM_IDLE  = 3'b001,
      CM_RUN   = 3'b010,
      CM_FINAL = 3'b100
   } pspst_cm_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } pspst_apb_t;

   typedef struct packed {
      logic signed [23:0] a0;
      logic signed [23:0] n11;
      logic signed [23:0] n12;
      logic signed [23:0] n13;
      logic signed [23:0] n21;
      logic signed [23:0] n22;
      logic signed [23:0] n23;
      logic signed [23:0] d12;
      logic signed [23:0] d13;
      logic signed [23:0] d22;
      logic signed [23:0] d23;
   } pspst_coef_t;

   // Q2.22 coefficients
   localparam pspst_coef_t LPF_800 = '{a0: 24'sd371794, n11: 24'sd124311,
      n12: 24'sd367183, n13: 24'sd124551, n21: 24'sd1049588, n22: 24'sd2097151,
      n23: 24'sd1047565, d12: -24'sd5967625, d13: 24'sd2145115,
      d22: -24'sd6305423, d23: 24'sd2608843};
   localparam pspst_coef_t LPF_1000 = '{a0: 24'sd543600, n11: 24'sd183374,
      n12: 24'sd367183, n13: 24'sd183810, n21: 24'sd1049820, n22: 24'sd2097151,
      n23: 24'sd1047334, d12: -24'sd5454704, d13: 24'sd1803999,
      d22: -24'sd5787970, d23: 24'sd2328033};

endpackage

// [rtl/pspst_top.sv]
// pressure signal path: sinc decimation, trim, IIR low-pass, self-test, APB regs
`timescale 1ns/1ns
module pspst_top #(
   parameter int unsigned ST_PERIOD_CYC = pspst_pkg::ST_PERIOD_DEF
) (
   input  wire logic                  clk_i,
   input  wire logic                  srst_i,
   input  wire logic                  ce_i,
   input  wire pspst_pkg::pspst_apb_t apb_i,
   output logic [31:0]                prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   output logic                       irq_o,
   output logic                       mod_clk_o,
   input  wire logic                  mod_bit_i,
   input  wire logic                  cm_over_i,
   input  wire logic                  uv_i,
   input  wire logic [7:0]            temp_i,
   output logic                       host_link_en_o
);

   typedef struct packed {
      logic [4:0]               div;
      logic                     mod_clk;
      logic [15:0]              i1;
      logic [15:0]              i2;
      logic [15:0]              i3;
      logic [15:0]              d1;
      logic [15:0]              d2;
      logic [15:0]              d3;
      logic [4:0]               k1;
      logic [19:0]              j1;
      logic [19:0]              j2;
      logic [19:0]              j3;
      logic [19:0]              f1;
      logic [19:0]              f2;
      logic [19:0]              f3;
      logic [1:0]               k2;
      logic [15:0]              sinc_w;
      logic                     sinc_vld;
      logic signed [31:0]       x1a;
      logic signed [31:0]       x2a;
      logic signed [31:0]       y1a;
      logic signed [31:0]       y2a;
      logic signed [31:0]       y1b;
      logic signed [31:0]       y2b;
      logic [15:0]              sense;
      logic [3:0]               sel;
      logic                     lpf;
      logic                     lock;
      pspst_pkg::pspst_cm_t     cm;
      logic                     fail;
      logic                     over;
      logic [23:0]              cnt;
      logic [15:0]              toff;
      logic [15:0]              tgain;
      logic [15:0]              tco;
      logic [15:0]              tnl;
      logic [pspst_pkg::IRQ_W-1:0] irq;
      logic [pspst_pkg::IRQ_W-1:0] msk;
      logic                     uv_q;
      logic [31:0]              rdata;
   } pspst_state_t;

   localparam logic [23:0] ST_LAST = 24'(ST_PERIOD_CYC - 1);

   pspst_state_t s_r;
   pspst_state_t s_nxt;

   logic                     mod_tick;
   logic [15:0]              c1;
   logic [15:0]              c2;
   logic [15:0]              c3;
   logic [19:0]              e1;
   logic [19:0]              e2;
   logic [19:0]              e3;
   logic [36:0]              prod;
   logic [36:0]              nsh;
   logic                     dig;
   logic                     fixm;
   logic                     running;
   logic signed [17:0]       xc;
   logic signed [47:0]       tsum;
   logic signed [47:0]       sq;
   logic [15:0]              trim16;
   logic signed [31:0]       xg;
   logic signed [31:0]       ya;
   logic signed [31:0]       yb;
   logic signed [31:0]       yo;
   logic [15:0]              filt16;
   pspst_pkg::pspst_coef_t   cf;
   logic                     acc;
   logic                     bad;
   logic                     wr;
   logic [pspst_pkg::IRQ_W-1:0] ev;
   logic [pspst_pkg::IRQ_W-1:0] w1c;
   logic [31:0]              rmux;

   function automatic logic signed [31:0] qmul(input logic signed [23:0] c,
                                               input logic signed [31:0] x);
      logic signed [63:0] p;
      p = 64'(c) * 64'(x);
      return 32'(p >>> pspst_pkg::COEF_Q);
   endfunction

   function automatic logic signed [31:0] biquad(input logic signed [23:0] b0,
      input logic signed [23:0] b1, input logic signed [23:0] b2,
      input logic signed [23:0] a1, input logic signed [23:0] a2,
      input logic signed [31:0] x0, input logic signed [31:0] x1,
      input logic signed [31:0] x2, input logic signed [31:0] y1,
      input logic signed [31:0] y2);
      logic signed [63:0] a;
      a = 64'(b0) * 64'(x0) + 64'(b1) * 64'(x1) + 64'(b2) * 64'(x2)
        - 64'(a1) * 64'(y1) - 64'(a2) * 64'(y2);
      return 32'(a >>> pspst_pkg::COEF_Q);
   endfunction

   always_comb begin
      s_nxt   = s_r;
      ev      = '0;
      w1c     = '0;
      rmux    = '0;
      dig     = s_r.sel[3:2] == pspst_pkg::ST_GRP_DIG;
      fixm    = s_r.sel[3:2] == pspst_pkg::ST_GRP_FIX;
      running = (s_r.cm != pspst_pkg::CM_IDLE) | dig | fixm;
      cf      = s_r.lpf ? pspst_pkg::LPF_1000 : pspst_pkg::LPF_800;

      // modulator clock: 20 clk cycles per bit, bit taken at period end
      mod_tick      = s_r.div == pspst_pkg::MOD_LAST;
      s_nxt.div     = mod_tick ? '0 : s_r.div + 5'h01;
      s_nxt.mod_clk = s_r.div < pspst_pkg::MOD_HALF;

      // first sinc3, wrapping integrators make the combs exact
      c1 = s_r.i3 - s_r.d1;
      c2 = c1 - s_r.d2;
      c3 = c2 - s_r.d3;
      e1 = s_r.j3 - s_r.f1;
      e2 = e1 - s_r.f2;
      e3 = e2 - s_r.f3;
      prod = {17'h00000, e3} * {20'h00000, pspst_pkg::NORM_MUL};
      nsh  = prod >> pspst_pkg::NORM_SHIFT;
      s_nxt.sinc_vld = 1'h0;
      if (mod_tick) begin
         s_nxt.i1 = s_r.i1 + {15'h0000, mod_bit_i};
         s_nxt.i2 = s_r.i2 + s_r.i1;
         s_nxt.i3 = s_r.i3 + s_r.i2;
         s_nxt.k1 = s_r.k1 + 5'h01;
         if (s_r.k1 == pspst_pkg::SINC1_LAST) begin
            s_nxt.k1 = '0;
            s_nxt.d1 = s_r.i3;
            s_nxt.d2 = c1;
            s_nxt.d3 = c2;
            s_nxt.j1 = s_r.j1 + {4'h0, c3};
            s_nxt.j2 = s_r.j2 + s_r.j1;
            s_nxt.j3 = s_r.j3 + s_r.j2;
            s_nxt.k2 = s_r.k2 + 2'h1;
            if (s_r.k2 == pspst_pkg::SINC2_LAST) begin
               s_nxt.f1       = s_r.j3;
               s_nxt.f2       = e1;
               s_nxt.f3       = e2;
               s_nxt.sinc_vld = 1'h1;
               // full scale truncates to FFFF, inside 16 bits; anything wider saturates
               s_nxt.sinc_w   = (|nsh[36:16]) ? 16'hFFFF : nsh[15:0];
               if (dig) begin
                  s_nxt.sinc_w = pspst_pkg::DIG_VAL[s_r.sel[1:0]];
               end
            end
         end
      end

      // trim: offset, gain, square-law and temperature terms
      xc = $signed({2'h0, s_r.sinc_w}) - $signed({2'h0, s_r.toff});
      sq = xc * xc;
      tsum = ((xc * $signed({1'h0, s_r.tgain})) >>> pspst_pkg::TRIM_SHIFT)
           + (($signed(sq[35:16]) * $signed(s_r.tnl)) >>> pspst_pkg::NL_SHIFT)
           + (($signed(s_r.tco) * $signed({1'h0, temp_i})) >>> pspst_pkg::TCO_SHIFT);
      if (tsum < 0) begin
         trim16 = '0;
      end else if (tsum > $signed({32'h00000000, 16'hFFFF})) begin
         trim16 = 16'hFFFF;
      end else begin
         trim16 = tsum[15:0];
      end

      // gain term, then two direct-form biquads
      xg = qmul(cf.a0, $signed({8'h00, trim16, 8'h00}));
      ya = biquad(cf.n11, cf.n12, cf.n13, cf.d12, cf.d13,
                  xg, s_r.x1a, s_r.x2a, s_r.y1a, s_r.y2a);
      yb = biquad(cf.n21, cf.n22, cf.n23, cf.d22, cf.d23,
                  ya, s_r.y1a, s_r.y2a, s_r.y1b, s_r.y2b);
      yo = yb >>> pspst_pkg::IIR_FRAC;
      if (yo < 0) begin
         filt16 = '0;
      end else if (|yo[31:16]) begin
         filt16 = 16'hFFFF;
      end else begin
         filt16 = yo[15:0];
      end

      if (s_r.sinc_vld) begin
         s_nxt.x1a = xg;
         s_nxt.x2a = s_r.x1a;
         s_nxt.y1a = ya;
         s_nxt.y2a = s_r.y1a;
         s_nxt.y1b = yb;
         s_nxt.y2b = s_r.y1b;
         if (!fixm) begin
            // forced word skips trim and filter so the result is exact
            s_nxt.sense  = dig ? s_r.sinc_w : filt16;
            ev[pspst_pkg::IRQ_SMP] = 1'h1;
         end
      end
      if (fixm) begin
         s_nxt.sense = pspst_pkg::FIX_VAL[s_r.sel[1:0]];
      end

      // common-mode test sequencer
      unique case (s_r.cm)
         pspst_pkg::CM_IDLE: begin
            if (s_r.sel == pspst_pkg::ST_CM) begin
               s_nxt.cm   = pspst_pkg::CM_RUN;
               s_nxt.fail = 1'h0;
               s_nxt.over = 1'h0;
               s_nxt.cnt  = '0;
            end
         end
         pspst_pkg::CM_RUN, pspst_pkg::CM_FINAL: begin
            s_nxt.over = s_r.over | cm_over_i;
            s_nxt.cnt  = s_r.cnt + 24'h000001;
            if (s_r.sel != pspst_pkg::ST_CM) begin
               s_nxt.cm = pspst_pkg::CM_FINAL;
            end
            if (s_r.cnt == ST_LAST) begin
               s_nxt.fail = s_r.over | cm_over_i;
               s_nxt.over = 1'h0;
               s_nxt.cnt  = '0;
               if (s_r.cm == pspst_pkg::CM_FINAL || s_r.sel != pspst_pkg::ST_CM) begin
                  s_nxt.cm = pspst_pkg::CM_IDLE;
                  ev[pspst_pkg::IRQ_DONE] = 1'h1;
               end
            end
         end
         default: begin
            s_nxt.cm = pspst_pkg::CM_IDLE;
         end
      endcase
      ev[pspst_pkg::IRQ_FAIL] = s_nxt.fail & ~s_r.fail;
      s_nxt.uv_q = uv_i;
      ev[pspst_pkg::IRQ_UV] = uv_i & ~s_r.uv_q;

      // APB slave
      acc = apb_i.psel & apb_i.penable;
      bad = 1'h1;
      unique case (apb_i.paddr)
         pspst_pkg::A_CFG: begin
            bad = 1'h0;
            rmux[3:0] = s_r.sel;
            rmux[pspst_pkg::CFG_LPF]  = s_r.lpf;
            rmux[pspst_pkg::CFG_LOCK] = s_r.lock;
         end
         pspst_pkg::A_STAT: begin
            bad = apb_i.pwrite;
            rmux[3:0] = {s_r.uv_q, s_r.lock, s_r.fail, running};
         end
         pspst_pkg::A_SENSE: begin
            bad = apb_i.pwrite;
            rmux[15:0] = s_r.sense;
         end
         pspst_pkg::A_TRIM0: begin
            bad = 1'h0;
            rmux = {s_r.tgain, s_r.toff};
         end
         pspst_pkg::A_TRIM1: begin
            bad = 1'h0;
            rmux = {s_r.tnl, s_r.tco};
         end
         pspst_pkg::A_IRQ: begin
            bad = 1'h0;
            rmux[pspst_pkg::IRQ_W-1:0] = s_r.irq;
         end
         pspst_pkg::A_MASK: begin
            bad = 1'h0;
            rmux[pspst_pkg::IRQ_W-1:0] = s_r.msk;
         end
         default: begin
            bad = 1'h1;
         end
      endcase
      if (apb_i.psel & ~apb_i.penable) begin
         s_nxt.rdata = (uv_i | bad) ? '0 : rmux;
      end
      wr = acc & apb_i.pwrite & ~bad & ~uv_i;
      if (wr) begin
         unique case (apb_i.paddr)
            pspst_pkg::A_CFG: begin
               if (!s_r.lock) begin
                  s_nxt.sel = apb_i.pwdata[3:0];
               end
               s_nxt.lpf = apb_i.pwdata[pspst_pkg::CFG_LPF];
               if (apb_i.pwdata[pspst_pkg::CFG_LOCK]) begin
                  s_nxt.lock = 1'h1;
               end
            end
            pspst_pkg::A_TRIM0: begin
               s_nxt.toff  = apb_i.pwdata[15:0];
               s_nxt.tgain = apb_i.pwdata[31:16];
            end
            pspst_pkg::A_TRIM1: begin
               s_nxt.tco = apb_i.pwdata[15:0];
               s_nxt.tnl = apb_i.pwdata[31:16];
            end
            pspst_pkg::A_IRQ: begin
               w1c = apb_i.pwdata[pspst_pkg::IRQ_W-1:0];
            end
            pspst_pkg::A_MASK: begin
               s_nxt.msk = apb_i.pwdata[pspst_pkg::IRQ_W-1:0];
            end
            default: begin
               s_nxt.msk = s_r.msk;
            end
         endcase
      end
      if (s_nxt.lock) begin
         s_nxt.sel = pspst_pkg::ST_OFF;
      end
      // a new event beats a clear in the same cycle
      s_nxt.irq = (s_r.irq & ~w1c) | ev;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_r       <= '0;
         s_r.tgain <= pspst_pkg::TRIM_GAIN_ONE;
         s_r.cm    <= pspst_pkg::CM_IDLE;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   // a frozen block cannot complete a transfer
   assign pready_o       = ce_i;
   assign pslverr_o      = acc & (bad | uv_i);
   assign prdata_o       = s_r.rdata;
   assign irq_o          = |(s_r.irq & s_r.msk);
   assign mod_clk_o      = s_r.mod_clk;
   assign host_link_en_o = ~s_r.uv_q;

endmodule

// [test/pspst_top_assertions.sv]
// port-level assertions for the pressure signal path top
`timescale 1ns/1ns
module pspst_chk #(
   parameter int unsigned ST_PERIOD_CYC = 50
) (
   input  wire logic                  clk_i,
   input  wire logic                  srst_i,
   input  wire logic                  ce_i,
   input  wire pspst_pkg::pspst_apb_t apb_i,
   input  wire logic [31:0]           prdata_o,
   input  wire logic                  pready_o,
   input  wire logic                  pslverr_o,
   input  wire logic                  mod_clk_o,
   input  wire logic                  uv_i,
   input  wire logic                  host_link_en_o
);
   logic [3:0]  sel_r;
   logic        lock_r;
   logic [11:0] age_r;
   logic        cfg_wr;
   logic        rd_ok;
   logic        mclk_q;
   logic        mseen_r;
   logic [4:0]  ph_r;
   // shadow of the selector, as the bus should have left it
   assign cfg_wr = apb_i.psel && apb_i.penable && apb_i.pwrite && ce_i && !uv_i
                   && apb_i.paddr == pspst_pkg::A_CFG;
   assign rd_ok  = apb_i.psel && apb_i.penable && !apb_i.pwrite && ce_i && !uv_i;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sel_r  <= 4'h0;
         lock_r <= 1'b0;
         age_r  <= 12'h000;
         mclk_q  <= 1'b0;
         mseen_r <= 1'b0;
         ph_r    <= 5'h00;
      end else if (ce_i) begin
         if (cfg_wr) begin
            lock_r <= lock_r | apb_i.pwdata[pspst_pkg::CFG_LOCK];
            sel_r  <= (lock_r | apb_i.pwdata[pspst_pkg::CFG_LOCK]) ? 4'h0 : apb_i.pwdata[3:0];
         end
         // phase length kept in a counter, the first phase after reset is partial
         mclk_q <= mod_clk_o;
         if (mod_clk_o != mclk_q) begin
            mseen_r <= 1'b1;
            ph_r    <= 5'h00;
         end else if (ph_r != 5'h1F) begin
            ph_r <= ph_r + 5'h01;
         end
         age_r <= cfg_wr ? 12'h000 : ((age_r == 12'hFFF) ? age_r : age_r + 12'h001);
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_high_phase;
      mseen_r && mclk_q && !mod_clk_o;
   endsequence
   sequence s_low_phase;
      mseen_r && !mclk_q && mod_clk_o;
   endsequence
   a_ready_is_ce: assert property (pready_o == ce_i)
      else $error("pready differs from clock enable");
   a_link_follows_uv: assert property (ce_i |=> host_link_en_o == !$past(uv_i))
      else $error("host link enable does not track undervoltage");
   a_uv_bus_err: assert property (apb_i.psel && apb_i.penable && uv_i |-> pslverr_o)
      else $error("access during undervoltage not refused");
   a_mod_high_ten: assert property (disable iff (srst_i || !ce_i)
      s_high_phase |-> ph_r == pspst_pkg::MOD_HALF - 5'h01)
      else $error("modulator clock high phase wrong");
   a_mod_low_ten: assert property (disable iff (srst_i || !ce_i)
      s_low_phase |-> ph_r == pspst_pkg::MOD_LAST - pspst_pkg::MOD_HALF)
      else $error("modulator clock low phase wrong");
   a_sel_readback: assert property (rd_ok && apb_i.paddr == pspst_pkg::A_CFG
      && !$past(uv_i) |-> prdata_o[3:0] == sel_r) else $error("selector readback wrong");
   a_lock_forces_zero: assert property (rd_ok && apb_i.paddr == pspst_pkg::A_CFG
      && $past(lock_r) && !$past(uv_i) |-> prdata_o[8] && prdata_o[3:0] == 4'h0)
      else $error("locked selector not zero");
   a_fixed_word: assert property (rd_ok && apb_i.paddr == pspst_pkg::A_SENSE
      && !$past(uv_i) && sel_r[3:2] == pspst_pkg::ST_GRP_FIX && age_r >= 12'h002
      |-> prdata_o[15:0] == pspst_pkg::FIX_VAL[sel_r[1:0]]) else $error("fixed word wrong");
   a_digital_word: assert property (rd_ok && apb_i.paddr == pspst_pkg::A_SENSE
      && !$past(uv_i) && sel_r[3:2] == pspst_pkg::ST_GRP_DIG && age_r >= 12'd1930
      |-> prdata_o[15:0] == pspst_pkg::DIG_VAL[sel_r[1:0]]) else $error("digital word wrong");
   a_running_set: assert property (rd_ok && apb_i.paddr == pspst_pkg::A_STAT
      && !$past(uv_i) && sel_r[2] && age_r >= 12'd4 |-> prdata_o[0])
      else $error("running flag clear during self-test");
endmodule
bind pspst_top pspst_chk #(.ST_PERIOD_CYC(ST_PERIOD_CYC)) pspst_chk_inst (
   .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .apb_i(apb_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .mod_clk_o(mod_clk_o), .uv_i(uv_i),
   .host_link_en_o(host_link_en_o));

// [test/pspst_afe_model.sv]
// analog front end stand-in: modulator bitstream and common-mode comparator
`timescale 1ns/1ns
module pspst_afe_model (
   input  wire logic mod_clk_i,
   input  wire logic cm_high_i,
   output logic      mod_bit_o,
   output logic      cm_over_o
);
   logic [1:0] phase_r = 2'd0;
   // three ones in four keeps the sinc words well inside range
   always_ff @(posedge mod_clk_i) begin
      phase_r <= phase_r + 2'd1;
   end
   assign mod_bit_o = (phase_r != 2'd0);
   assign cm_over_o = cm_high_i;
endmodule

// [test/pspst_top_tb_top.sv]
// self-checking bench for the pressure signal path registers and self-test
`timescale 1ns/1ns
module pspst_top_tb_top;
   localparam int unsigned PER = 50;
   logic                  clk_i = 1'b0;
   logic                  srst_i = 1'b1;
   logic                  ce_i = 1'b1;
   logic                  uv_i = 1'b0;
   logic                  cm_high = 1'b0;
   pspst_pkg::pspst_apb_t apb_i = '0;
   logic [31:0]           prdata_o;
   logic                  pready_o, pslverr_o, irq_o, mod_clk_o;
   logic                  mod_bit_i, cm_over_i, host_link_en_o;
   logic [31:0]           rd;
   logic                  err;
   int                    error_cnt = 0;
   int                    comparisons = 0;
   always #25 clk_i = ~clk_i;
   pspst_top #(.ST_PERIOD_CYC(PER)) pspst_top_inst (
      .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .apb_i(apb_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .mod_clk_o(mod_clk_o),
      .mod_bit_i(mod_bit_i), .cm_over_i(cm_over_i), .uv_i(uv_i), .temp_i(8'h40),
      .host_link_en_o(host_link_en_o));
   pspst_afe_model pspst_afe_model_inst (.mod_clk_i(mod_clk_o), .cm_high_i(cm_high),
      .mod_bit_o(mod_bit_i), .cm_over_o(cm_over_i));
   task automatic summarize();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // pready is waited for, never assumed
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk_i);
      apb_i.penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      apb_i <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
      xfer(1'b0, a, 32'h0);
      check(what, rd & m, e);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      rdchk(pspst_pkg::A_CFG, 32'hFFFFFFFF, 32'h0, "cfg reset");
      rdchk(pspst_pkg::A_TRIM0, 32'hFFFFFFFF, 32'h40000000, "trim0 reset");
      rdchk(pspst_pkg::A_TRIM1, 32'hFFFFFFFF, 32'h0, "trim1 reset");
      rdchk(pspst_pkg::A_MASK, 32'hFFFFFFFF, 32'h0, "mask reset");
      xfer(1'b0, 8'h1C, 32'h0);
      check("unmapped error", 32'(err), 32'h1);
      xfer(1'b1, pspst_pkg::A_STAT, 32'h1);
      check("read-only error", 32'(err), 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(pspst_pkg::A_CFG, 32'(4 + i));
         rdchk(pspst_pkg::A_SENSE, 32'hFFFF, 32'(pspst_pkg::FIX_VAL[i]), "fixed");
         rdchk(pspst_pkg::A_STAT, 32'h1, 32'h1, "fixed running");
      end
      for (int i = 0; i < 4; i++) begin
         wr(pspst_pkg::A_CFG, 32'(12 + i));
         repeat (2) begin
            cyc(1925);
            rdchk(pspst_pkg::A_SENSE, 32'hFFFF, 32'(pspst_pkg::DIG_VAL[i]), "dig");
         end
         rdchk(pspst_pkg::A_STAT, 32'h1, 32'h1, "dig running");
      end
      wr(pspst_pkg::A_CFG, 32'h0);
      rdchk(pspst_pkg::A_STAT, 32'h1, 32'h0, "normal idle");
      wr(pspst_pkg::A_IRQ, 32'hF);
      wr(pspst_pkg::A_CFG, 32'h1);
      rdchk(pspst_pkg::A_STAT, 32'h3, 32'h1, "cm start");
      cyc(2 * PER);
      rdchk(pspst_pkg::A_STAT, 32'h3, 32'h1, "cm pass");
      cm_high <= 1'b1;
      cyc(2 * PER);
      rdchk(pspst_pkg::A_STAT, 32'h3, 32'h3, "cm fail");
      cm_high <= 1'b0;
      cyc(2 * PER);
      rdchk(pspst_pkg::A_STAT, 32'h3, 32'h1, "cm repeat");
      cm_high <= 1'b1;
      wr(pspst_pkg::A_CFG, 32'h0);
      cyc(PER + 2);
      rdchk(pspst_pkg::A_STAT, 32'h3, 32'h2, "cm final");
      rdchk(pspst_pkg::A_IRQ, 32'h4, 32'h4, "cm done event");
      check("irq masked", 32'(irq_o), 32'h0);
      wr(pspst_pkg::A_MASK, 32'h4);
      cyc(2);
      check("irq raised", 32'(irq_o), 32'h1);
      wr(pspst_pkg::A_IRQ, 32'h4);
      cyc(2);
      check("irq cleared", 32'(irq_o), 32'h0);
      cm_high <= 1'b0;
      wr(pspst_pkg::A_CFG, 32'h1);
      rdchk(pspst_pkg::A_STAT, 32'h3, 32'h1, "cm reselect");
      wr(pspst_pkg::A_CFG, 32'h0);
      cyc(PER + 2);
      uv_i <= 1'b1;
      cyc(2);
      check("link cut", 32'(host_link_en_o), 32'h0);
      xfer(1'b1, pspst_pkg::A_TRIM1, 32'h1234);
      check("uv error", 32'(err), 32'h1);
      uv_i <= 1'b0;
      cyc(2);
      check("link back", 32'(host_link_en_o), 32'h1);
      rdchk(pspst_pkg::A_TRIM1, 32'hFFFFFFFF, 32'h0, "uv no write");
      rdchk(pspst_pkg::A_IRQ, 32'h8, 32'h8, "uv event");
      ce_i <= 1'b0;
      cyc(3);
      check("frozen ready", 32'(pready_o), 32'h0);
      ce_i <= 1'b1;
      wr(pspst_pkg::A_CFG, 32'h104);
      rdchk(pspst_pkg::A_CFG, 32'h10F, 32'h100, "lock clears");
      wr(pspst_pkg::A_CFG, 32'h105);
      rdchk(pspst_pkg::A_CFG, 32'hF, 32'h0, "locked write");
      rdchk(pspst_pkg::A_STAT, 32'h5, 32'h4, "locked stat");
      srst_i <= 1'b1;
      cyc(6);
      srst_i <= 1'b0;
      wr(pspst_pkg::A_CFG, 32'h5);
      rdchk(pspst_pkg::A_CFG, 32'h10F, 32'h5, "unlocked by reset");
      rdchk(pspst_pkg::A_SENSE, 32'hFFFF, 32'hAAAA, "fixed after reset");
      summarize();
   end
   // the longest scenario needs some 16000 cycles
   initial begin
      cyc(40000);
      error_cnt++;
      summarize();
   end
endmodule
